// *** afss_defines.svh ***
// Constants for the analog frequency source selection block
`ifndef AFSS_DEFINES_SVH
`define AFSS_DEFINES_SVH
`define AFSS_DATA_W 12
`define AFSS_SRC_ANALOG 2'h1
`define AFSS_ALT_CURRENT 2'h0
`define AFSS_ALT_BIPOLAR 2'h1
`define AFSS_TRIM_NONE 2'h0
`define AFSS_TRIM_FWD 2'h1
`define AFSS_TRIM_BOTH 2'h2
`define AFSS_FILT_MIN 5'h01
`define AFSS_FILT_MAX 5'h1e
`define AFSS_FILT_RST 5'h08
`define AFSS_SAMPLE_NS 1000
`define AFSS_CLK_NS 5
`define AFSS_SAMPLE_CYC (`AFSS_SAMPLE_NS / `AFSS_CLK_NS)
`define AFSS_ADDR_ALT 4'h0
`define AFSS_ADDR_TRIM 4'h1
`define AFSS_ADDR_FILT 4'h2
`define AFSS_ADDR_SRC 4'h3
`define AFSS_ADDR_STAT 4'h4
`define AFSS_ADDR_CMD 4'h5
`endif

// *** afss_pkg.sv ***
// Types for the analog frequency source selection block
package afss_pkg;
	typedef enum logic [1:0] {
		AFSS_MAIN_VOLT = 2'b00,
		AFSS_MAIN_AMP = 2'b01,
		AFSS_MAIN_BIP = 2'b10,
		AFSS_MAIN_OFF = 2'b11
	} afss_main_t;
endpackage

// *** afss_avg_filter.sv ***
// Block average filter for one analog channel
`timescale 1ns/1ps
`include "afss_defines.svh"
module afss_avg_filter #(
	parameter int W = 12
) (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	// Sample stream
	input wire logic i_sample_en,
	input wire logic [4:0] i_depth,
	input wire logic signed [W-1:0] i_sample,
	// Filtered value
	output logic signed [W-1:0] o_avg
);
	logic signed [W+4:0] acc_ff, nxt_acc;
	logic [4:0] cnt_ff, nxt_cnt;
	logic signed [W-1:0] avg_ff, nxt_avg;

	// Block average over depth samples; a depth at or below count ends the block at the next sample, dividing count+1 samples by depth
	always_comb
	begin
		nxt_acc = acc_ff;
		nxt_cnt = cnt_ff;
		nxt_avg = avg_ff;
		if (i_sample_en)
		begin
			if (cnt_ff + 5'h01 >= i_depth)
			begin
				nxt_avg = W'((acc_ff + (W+5)'(i_sample)) / $signed({1'b0, i_depth}));
				nxt_acc = '0;
				nxt_cnt = '0;
			end
			else
			begin
				nxt_acc = acc_ff + (W+5)'(i_sample);
				nxt_cnt = cnt_ff + 5'h01;
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			acc_ff <= '0;
			cnt_ff <= '0;
			avg_ff <= '0;
		end
		else
		begin
			acc_ff <= nxt_acc;
			cnt_ff <= nxt_cnt;
			avg_ff <= nxt_avg;
		end
	end

	assign o_avg = avg_ff;
endmodule // afss_avg_filter

// *** afss_select.sv ***
// Analog frequency source selection with shared input filter
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "afss_defines.svh"
module afss_select
	import afss_pkg::*;
#(
	parameter int W = `AFSS_DATA_W,
	parameter int SAMPLE_CYC = `AFSS_SAMPLE_CYC
) (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	// Register port
	input wire logic [3:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [15:0] o_rdata,
	// Selector terminal (pin) and its assignment status
	input wire logic i_analog_type_select,
	input wire logic i_sel_assigned,
	// Analog samples, already converted, from outside the clock domain
	input wire logic [W-1:0] i_volt_line,
	input wire logic [W-1:0] i_ampere_line,
	input wire logic signed [W-1:0] i_signed_aux_line,
	// Frequency command path
	output logic [W:0] o_freq_cmd,
	output logic o_reverse,
	output logic o_cmd_valid,
	output afss_pkg::afss_main_t o_main_src
);
	import afss_pkg::*;

	// ==========================================
	// Input synchronisers
	// ==========================================
	logic [1:0] sel_sync_ff;
	logic [1:0] asg_sync_ff;
	logic [W-1:0] v_meta_ff, v_sync_ff;
	logic [W-1:0] a_meta_ff, a_sync_ff;
	logic [W-1:0] b_meta_ff, b_sync_ff;

	// Analog words are assumed held stable by the converter across several cycles
	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			sel_sync_ff <= '0;
			asg_sync_ff <= '0;
			v_meta_ff <= '0;
			v_sync_ff <= '0;
			a_meta_ff <= '0;
			a_sync_ff <= '0;
			b_meta_ff <= '0;
			b_sync_ff <= '0;
		end
		else
		begin
			sel_sync_ff <= {sel_sync_ff[0], i_analog_type_select};
			asg_sync_ff <= {asg_sync_ff[0], i_sel_assigned};
			v_meta_ff <= i_volt_line;
			v_sync_ff <= v_meta_ff;
			a_meta_ff <= i_ampere_line;
			a_sync_ff <= a_meta_ff;
			b_meta_ff <= i_signed_aux_line;
			b_sync_ff <= b_meta_ff;
		end
	end

	// ==========================================
	// Registers
	// ==========================================
	logic [1:0] alt_ff, nxt_alt;
	logic [1:0] trim_ff, nxt_trim;
	logic [4:0] filt_ff, nxt_filt;
	logic [1:0] src_ff, nxt_src;
	logic [15:0] rdata_ff, nxt_rdata;

	always_comb
	begin
		nxt_alt = alt_ff;
		nxt_trim = trim_ff;
		nxt_filt = filt_ff;
		nxt_src = src_ff;
		if (i_wr)
		begin
			if (i_addr == `AFSS_ADDR_ALT)
				nxt_alt = i_wdata[1:0];
			else if (i_addr == `AFSS_ADDR_TRIM)
			begin
				if (i_wdata[1:0] <= `AFSS_TRIM_BOTH)
					nxt_trim = i_wdata[1:0];
			end
			else if (i_addr == `AFSS_ADDR_FILT)
			begin
				// Out-of-range writes are dropped; the old setting stays
				if (i_wdata[15:5] == '0 && i_wdata[4:0] >= `AFSS_FILT_MIN
					&& i_wdata[4:0] <= `AFSS_FILT_MAX)
					nxt_filt = i_wdata[4:0];
			end
			else if (i_addr == `AFSS_ADDR_SRC)
				nxt_src = i_wdata[1:0];
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			alt_ff <= `AFSS_ALT_CURRENT;
			trim_ff <= `AFSS_TRIM_NONE;
			filt_ff <= `AFSS_FILT_RST;
			src_ff <= `AFSS_SRC_ANALOG;
		end
		else
		begin
			alt_ff <= nxt_alt;
			trim_ff <= nxt_trim;
			filt_ff <= nxt_filt;
			src_ff <= nxt_src;
		end
	end

	// ==========================================
	// Sample rate divider and shared filters
	// ==========================================
	localparam int CW = $clog2(SAMPLE_CYC + 1);
	logic [CW-1:0] div_ff, nxt_div;
	logic sample_en;

	always_comb
	begin
		sample_en = (div_ff == CW'(SAMPLE_CYC - 1));
		nxt_div = sample_en ? '0 : div_ff + CW'(1);
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			div_ff <= '0;
		else
			div_ff <= nxt_div;
	end

	logic signed [W:0] chan_in [3];
	logic signed [W:0] chan_avg [3];
	assign chan_in[0] = {1'b0, v_sync_ff};
	assign chan_in[1] = {1'b0, a_sync_ff};
	assign chan_in[2] = {b_sync_ff[W-1], b_sync_ff};

	// Same depth feeds every channel
	for (genvar g = 0; g < 3; g++)
	begin : g_filt
		afss_avg_filter #(.W(W + 1)) u_filt (
			.i_sys_clk(i_sys_clk),
			.i_rst_b(i_rst_b),
			.i_sample_en(sample_en),
			.i_depth(filt_ff),
			.i_sample(chan_in[g]),
			.o_avg(chan_avg[g])
		);
	end

	// ==========================================
	// Source selection
	// ==========================================
	afss_main_t main_sel;
	logic trim_on;
	logic rev_ok;
	// Voltage plus current plus trim can pass twice full scale; three spare bits keep the sum from wrapping
	logic signed [W+2:0] sum;
	logic [W:0] nxt_cmd;
	logic nxt_rev;
	logic [W:0] cmd_ff;
	logic rev_ff;
	logic valid_ff;
	afss_main_t main_ff;

	always_comb
	begin
		main_sel = AFSS_MAIN_VOLT;
		if (!asg_sync_ff[1])
			main_sel = (trim_ff == `AFSS_TRIM_NONE) ? AFSS_MAIN_BIP : AFSS_MAIN_VOLT;
		else if (sel_sync_ff[1])
			main_sel = (alt_ff == `AFSS_ALT_BIPOLAR) ? AFSS_MAIN_BIP : AFSS_MAIN_AMP;
		if (src_ff != `AFSS_SRC_ANALOG)
			main_sel = AFSS_MAIN_OFF;
		trim_on = (trim_ff != `AFSS_TRIM_NONE) && (main_sel == AFSS_MAIN_VOLT || main_sel == AFSS_MAIN_AMP);
		rev_ok = (trim_ff == `AFSS_TRIM_BOTH) || (main_sel == AFSS_MAIN_BIP);
		sum = '0;
		if (!asg_sync_ff[1] && main_sel == AFSS_MAIN_VOLT)
			sum = (W+3)'(chan_avg[0]) + (W+3)'(chan_avg[1]);
		else if (main_sel == AFSS_MAIN_VOLT)
			sum = (W+3)'(chan_avg[0]);
		else if (main_sel == AFSS_MAIN_AMP)
			sum = (W+3)'(chan_avg[1]);
		else if (main_sel == AFSS_MAIN_BIP)
			sum = (W+3)'(chan_avg[2]);
		if (trim_on)
			sum = sum + (W+3)'(chan_avg[2]);
		nxt_rev = 1'b0;
		nxt_cmd = '0;
		if (main_sel != AFSS_MAIN_OFF)
		begin
			if (sum < 0)
			begin
				// Negative sign reverses only when allowed, else clamps to zero
				nxt_rev = rev_ok;
				nxt_cmd = rev_ok ? (W+1)'(-sum) : '0;
			end
			else
				nxt_cmd = (sum > (W+3)'({1'b0, {W{1'b1}}})) ? {1'b0, {W{1'b1}}} : (W+1)'(sum);
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			cmd_ff <= '0;
			rev_ff <= 1'b0;
			valid_ff <= 1'b0;
			main_ff <= AFSS_MAIN_OFF;
		end
		else
		begin
			cmd_ff <= nxt_cmd;
			rev_ff <= nxt_rev;
			valid_ff <= (main_sel != AFSS_MAIN_OFF);
			main_ff <= main_sel;
		end
	end

	// ==========================================
	// Read port
	// ==========================================
	always_comb
	begin
		nxt_rdata = 16'h0000;
		if (i_rd)
		begin
			if (i_addr == `AFSS_ADDR_ALT)
				nxt_rdata = {14'h0000, alt_ff};
			else if (i_addr == `AFSS_ADDR_TRIM)
				nxt_rdata = {14'h0000, trim_ff};
			else if (i_addr == `AFSS_ADDR_FILT)
				nxt_rdata = {11'h000, filt_ff};
			else if (i_addr == `AFSS_ADDR_SRC)
				nxt_rdata = {14'h0000, src_ff};
			else if (i_addr == `AFSS_ADDR_STAT)
				nxt_rdata = {10'h000, asg_sync_ff[1], sel_sync_ff[1], valid_ff, rev_ff, main_ff};
			else if (i_addr == `AFSS_ADDR_CMD)
				nxt_rdata = 16'((W+1)'(cmd_ff));
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			rdata_ff <= '0;
		else
			rdata_ff <= nxt_rdata;
	end

	assign o_rdata = rdata_ff;
	assign o_freq_cmd = cmd_ff;
	assign o_reverse = rev_ff;
	assign o_cmd_valid = valid_ff;
	assign o_main_src = main_ff;
endmodule // afss_select

// *** afss_select_properties.sv ***
// Checker for the analog frequency source selection block
`timescale 1ns/1ps
module afss_select_properties
	import afss_pkg::*;
(
	// Clock, reset and register writes
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire logic [3:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	// Selector and command outputs
	input wire logic i_analog_type_select,
	input wire logic i_sel_assigned,
	input wire logic [12:0] o_freq_cmd,
	input wire logic o_reverse,
	input wire logic o_cmd_valid,
	input wire afss_pkg::afss_main_t o_main_src
);
	// ====
	// Shadow of alternate source [1:0] and trim mode [3:2]
	logic [3:0] mode_ff, nxt_mode;
	always_comb
	begin
		nxt_mode = mode_ff;
		if (i_wr && i_addr == 4'h0)
			nxt_mode[1:0] = i_wdata[1:0];
		if (i_wr && i_addr == 4'h1 && i_wdata < 16'h3)
			nxt_mode[3:2] = i_wdata[1:0];
	end
	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			mode_ff <= 4'h0;
		else
			mode_ff <= nxt_mode;
	end
	// ====
	// Properties; four held cycles cover the pin synchroniser and output register
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rst_b);
	sequence sel_held(bit v);
		(i_sel_assigned && i_analog_type_select == v) [*4];
	endsequence
	sequence no_sel;
		(!i_sel_assigned) [*4];
	endsequence
	off_state_a: assert property (!o_cmd_valid |-> o_main_src == AFSS_MAIN_OFF && o_freq_cmd == 13'h0)
		else $error("idle command not parked");
	src_gate_a: assert property (i_wr && i_addr == 4'h3 && i_wdata == 16'h0 |-> ##2 !o_cmd_valid)
		else $error("command still valid with analog source off");
	volt_main_a: assert property (sel_held(1'h0) ##0 o_cmd_valid |-> o_main_src == AFSS_MAIN_VOLT)
		else $error("voltage input not main");
	amp_main_a: assert property (sel_held(1'h1) ##0 o_cmd_valid && mode_ff[1:0] == 2'h0 && $stable(mode_ff)
		|-> o_main_src == AFSS_MAIN_AMP)
		else $error("current input not main");
	bip_main_a: assert property (sel_held(1'h1) ##0 o_cmd_valid && mode_ff[1:0] == 2'h1 && $stable(mode_ff)
		|-> o_main_src == AFSS_MAIN_BIP)
		else $error("bipolar input not main");
	no_alt_a: assert property (no_sel ##0 o_cmd_valid |-> o_main_src != AFSS_MAIN_AMP)
		else $error("current input chosen without selector");
	rev_limit_a: assert property (o_reverse |-> o_main_src == AFSS_MAIN_BIP || mode_ff[3:2] == 2'h2
		|| $past(mode_ff[3:2]) == 2'h2)
		else $error("reverse outside permitted modes");
	uni_aux_a: assert property (no_sel ##0 mode_ff[3:2] == 2'h1 && $stable(mode_ff) |-> !o_reverse)
		else $error("reverse with unipolar trim");
endmodule // afss_select_properties
bind afss_select afss_select_properties u_props (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_wr(i_wr), .i_analog_type_select(i_analog_type_select), .i_sel_assigned(i_sel_assigned),
	.o_freq_cmd(o_freq_cmd), .o_reverse(o_reverse), .o_cmd_valid(o_cmd_valid), .o_main_src(o_main_src));

// *** afss_src_model.sv ***
// Analog sources and selector terminal facing the block
`timescale 1ns/1ps
module afss_src_model (
	// Clock and levels to present
	input wire logic i_sys_clk,
	input wire logic [37:0] i_set,
	// Lines into the block
	output logic o_sel,
	output logic o_asg,
	output logic [11:0] o_volt,
	output logic [11:0] o_amp,
	output logic signed [11:0] o_aux
);
	initial {o_sel, o_asg, o_volt, o_amp, o_aux} = 38'h0;
	// Levels move only on an edge and then hold, as converted samples must
	always @(posedge i_sys_clk)
		{o_sel, o_asg, o_volt, o_amp, o_aux} <= i_set;
endmodule // afss_src_model

// *** afss_select_tb_top.sv ***
// Self-checking bench for the analog frequency source selection block
`timescale 1ns/1ps
module afss_select_tb_top;
	import afss_pkg::*;
	logic i_sys_clk = 1'h0;
	logic i_rst_b = 1'h0;
	logic i_wr = 1'h0;
	logic i_rd = 1'h0;
	logic rd_ff = 1'h0;
	logic [3:0] i_addr = 4'h0;
	logic [15:0] i_wdata = 16'h0;
	logic [15:0] o_rdata, msk;
	logic [37:0] lvl = 38'h0;
	logic [12:0] cmd;
	logic rev, vld, sel, asg;
	logic [11:0] volt, amp, aux;
	afss_main_t msrc;
	logic [15:0] exp_q[$], msk_q[$];
	int mismatches = 0;
	int samples_checked = 0;
	int seed = 23;
	always #2.5 i_sys_clk = ~i_sys_clk;
	afss_src_model u_src (.i_sys_clk(i_sys_clk), .i_set(lvl), .o_sel(sel), .o_asg(asg), .o_volt(volt), .o_amp(amp),
		.o_aux(aux));
	afss_select #(.SAMPLE_CYC(2)) u_dut (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_analog_type_select(sel), .i_sel_assigned(asg),
		.i_volt_line(volt), .i_ampere_line(amp), .i_signed_aux_line(aux), .o_freq_cmd(cmd), .o_reverse(rev),
		.o_cmd_valid(vld), .o_main_src(msrc));
	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		samples_checked++;
		if (seen !== want)
		begin
			mismatches++;
			$display("unexpected at %0t: read %h, expected %h", $time, seen, want);
		end
	endtask
	// One register access; a read leaves its expected value for the monitor
	task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] d, input logic [15:0] m = 16'hffff);
		if (!w)
		begin
			exp_q.push_back(d);
			msk_q.push_back(m);
		end
		@(posedge i_sys_clk);
		i_wr <= w;
		i_rd <= !w;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_sys_clk);
		i_wr <= 1'h0;
		i_rd <= 1'h0;
	endtask
	task automatic complete_run;
		$display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
		if (mismatches == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	always @(posedge i_sys_clk)
	begin
		rd_ff <= i_rd;
		if (rd_ff && exp_q.size() == 0)
		begin
			mismatches++;
			$display("unexpected at %0t: read data with no expected value", $time);
		end
		else if (rd_ff)
		begin
			msk = msk_q.pop_front();
			check(o_rdata & msk, exp_q.pop_front() & msk);
		end
	end
	initial
	begin
		int c, tr, al, sl, as, iv, ia, ix, mv, v;
		logic bp, ok, rv;
		repeat (2) @(posedge i_sys_clk);
		i_rst_b <= 1'h1;
		acc(1'h0, 4'h3, 16'h1);
		acc(1'h0, 4'h6, 16'h0);
		acc(1'h1, 4'h2, 16'h0);
		acc(1'h1, 4'h2, 16'h1f);
		acc(1'h1, 4'h1, 16'h3);
		acc(1'h0, 4'h2, 16'h8);
		acc(1'h0, 4'h1, 16'h0);
		acc(1'h1, 4'h2, 16'h1);
		acc(1'h0, 4'h2, 16'h1);
		for (int k = 0; k < 30; k++)
		begin
			c = k % 15;
			as = c < 12;
			tr = as ? c / 4 : c - 12;
			al = c % 2;
			sl = (c / 2) % 2;
			iv = {$random(seed)} % 4096;
			ia = {$random(seed)} % 4096;
			ix = $random(seed) % 2048;
			acc(1'h1, 4'h1, tr[15:0]);
			acc(1'h1, 4'h0, al[15:0]);
			lvl <= {sl[0], as[0], iv[11:0], ia[11:0], ix[11:0]};
			repeat (12) @(posedge i_sys_clk);
			bp = as ? (sl && al) : (tr == 0);
			mv = !as ? (tr == 0 ? ix : iv + ia) : (!sl ? iv : (al ? ix : ia));
			v = mv + ((tr != 0 && !bp) ? ix : 0);
			ok = bp || tr == 2;
			rv = ok && v < 0;
			v = v < 0 ? (ok ? -v : 0) : (v > 4095 ? 4095 : v);
			check({3'h0, cmd}, v[15:0]);
			check({13'h0, rev, msrc}, {13'h0, rv, bp ? 2'h2 : {1'h0, as[0] && sl[0]}});
			acc(1'h0, 4'h4, {10'h0, as[0], sl[0], 1'h1, rv, bp ? 2'h2 : {1'h0, as[0] && sl[0]}});
			acc(1'h0, 4'h5, v[15:0]);
		end
		// Deeper filter on a steady voltage input must settle to that input
		acc(1'h1, 4'h1, 16'h0);
		acc(1'h1, 4'h2, 16'h4);
		lvl <= {2'h1, 12'h9a4, 12'h123, 12'h000};
		repeat (40) @(posedge i_sys_clk);
		acc(1'h0, 4'h5, 16'h09a4);
		acc(1'h1, 4'h3, 16'h0);
		repeat (4) @(posedge i_sys_clk);
		check({15'h0, vld}, 16'h0);
		acc(1'h0, 4'h4, 16'h3, 16'hf);
		for (int i = 0; i < 20 && exp_q.size() > 0; i++)
			@(posedge i_sys_clk);
		if (exp_q.size() > 0)
		begin
			mismatches++;
			$display("unexpected at %0t: read results still pending", $time);
		end
		complete_run();
	end
endmodule // afss_select_tb_top
